// ==== hdl/ssrep_top.sv ====
// Sideband reset, interrupt and multicast event pin logic of the switch.
`default_nettype none
// What this block does
// - All logic is reset asynchronously while hard_reset_n is low.
// - A valid link reset request accepted by any port asserts link_reset_out_n.
// - Without self-reset the output stays asserted until software clears the request.
// - With self-reset the output stays asserted until the self-reset sequence ends.
// - Hard reset deasserts link_reset_out_n and it stays deasserted after release.
// - link_reset_out_n is open drain: pulled low when asserted, released otherwise.
// - irq_out_n is open drain, pulled low while an interrupt is pending.
// - As an input, each edge of mcast_event_pin sends an event symbol on all ports.
// - As an output, mcast_event_pin toggles on an event symbol from an enabled port; symbols inside the hold window are dropped.
// - The driver of mcast_event_pin keeps it stable 10 cycles around each transition.
module ssrep_top #(
	parameter int unsigned NUM_PORTS  = 16,
	parameter int unsigned SELF_CYCLES = ssrep_pkg::SELF_RST_CYCLES
) (
	// Clock and hard reset.
	input  wire logic                 clk,
	input  wire logic                 hard_reset_n,
	// Link reset requests and control.
	input  wire logic [NUM_PORTS-1:0] port_reset_req,
	input  wire logic                 self_reset_en,
	input  wire logic                 reset_req_clear,
	output logic                      self_reset_active,
	// Open-drain software reset output.
	output logic                      link_reset_out_n_o,
	output logic                      link_reset_out_n_oe,
	// Interrupt source and open-drain interrupt output.
	input  wire logic                 irq_pending,
	output logic                      irq_out_n_o,
	output logic                      irq_out_n_oe,
	// Multicast event pin and direction.
	input  wire logic                 mcast_dir_out,
	input  wire logic                 mcast_event_pin_i,
	output logic                      mcast_event_pin_o,
	output logic                      mcast_event_pin_oe,
	// Multicast event symbols to and from the ports.
	input  wire logic [NUM_PORTS-1:0] mcast_sym_rx,
	input  wire logic [NUM_PORTS-1:0] mcast_sym_en,
	output logic                      mcast_sym_tx_all,
	output logic                      mcast_drop
);
	localparam int unsigned HOLD = ssrep_pkg::MCE_HOLD_CYCLES;

	typedef struct packed {
		ssrep_pkg::ssrep_rst_state_type state;
		logic [31:0]                    self_cnt;
		logic                           rst_out;
		logic                           self_act;
		logic                           irq;
		logic                           level;
		logic                           dir_out;
		logic [7:0]                     hold_cnt;
		logic                           tx;
		logic                           drop;
	} ssrep_st_type;

	ssrep_st_type s_q;
	ssrep_st_type s_d;
	logic         pin_edge;
	logic         any_req;
	logic         any_sym;

	ssrep_sync u_sync (
		.clk        (clk),
		.rstn       (hard_reset_n),
		.din        (mcast_event_pin_i),
		.dout       (),
		.edge_pulse (pin_edge)
	);

	assign any_req = |port_reset_req;
	assign any_sym = |(mcast_sym_rx & mcast_sym_en);

	always_comb begin
		s_d         = s_q;
		s_d.tx      = 1'h0;
		s_d.drop    = 1'h0;
		s_d.irq     = irq_pending;
		s_d.dir_out = mcast_dir_out;
		if (s_q.hold_cnt != 8'h00) begin
			s_d.hold_cnt = s_q.hold_cnt - 8'h01;
		end
		case (s_q.state)
			ssrep_pkg::SSREP_RST_IDLE: begin
				if (any_req) begin
					s_d.rst_out = 1'h1;
					if (self_reset_en) begin
						s_d.state    = ssrep_pkg::SSREP_RST_HOLD_SELF;
						s_d.self_cnt = 32'(SELF_CYCLES);
						s_d.self_act = 1'h1;
					end else begin
						s_d.state = ssrep_pkg::SSREP_RST_HOLD_SW;
					end
				end
			end
			ssrep_pkg::SSREP_RST_HOLD_SW: begin
				// A request arriving with the clear keeps the output asserted.
				if (reset_req_clear && !any_req) begin
					s_d.rst_out = 1'h0;
					s_d.state   = ssrep_pkg::SSREP_RST_IDLE;
				end
			end
			ssrep_pkg::SSREP_RST_HOLD_SELF: begin
				if (s_q.self_cnt <= 32'h1) begin
					s_d.rst_out  = 1'h0;
					s_d.self_act = 1'h0;
					s_d.self_cnt = 32'h0;
					s_d.state    = ssrep_pkg::SSREP_RST_IDLE;
				end else begin
					s_d.self_cnt = s_q.self_cnt - 32'h1;
				end
			end
			default: begin
				s_d.state   = ssrep_pkg::SSREP_RST_IDLE;
				s_d.rst_out = 1'h0;
			end
		endcase
		if (s_q.dir_out) begin
			// Received symbols toggle the pin; a toggle inside the hold window would
			// violate the far side's sampling, so it is dropped and flagged.
			if (any_sym) begin
				if (s_q.hold_cnt == 8'h00) begin
					s_d.level    = ~s_q.level;
					s_d.hold_cnt = 8'(HOLD);
				end else begin
					s_d.drop = 1'h1;
				end
			end
		end else if (pin_edge) begin
			s_d.tx = 1'h1;
		end
	end

	always_ff @(posedge clk or negedge hard_reset_n) begin
		if (!hard_reset_n) begin
			s_q       <= '0;
			s_q.state <= ssrep_pkg::SSREP_RST_IDLE;
			s_q.level <= ssrep_pkg::MCE_LEVEL_RST;
			s_q.rst_out <= 1'h0;
		end else begin
			s_q <= s_d;
		end
	end

	// Open-drain link reset and interrupt pins: the data is always low, only the enable moves; the event pin drives its level.
	assign link_reset_out_n_o  = 1'h0;
	assign link_reset_out_n_oe = s_q.rst_out;
	assign irq_out_n_o         = 1'h0;
	assign irq_out_n_oe        = s_q.irq;
	assign mcast_event_pin_o   = s_q.level;
	assign mcast_event_pin_oe  = s_q.dir_out;
	assign mcast_sym_tx_all    = s_q.tx;
	assign mcast_drop          = s_q.drop;
	assign self_reset_active   = s_q.self_act;
endmodule : ssrep_top
`default_nettype wire

// ==== inc/ssrep_pkg.sv ====
// Package of constants and types for the switch sideband reset and event pin logic.
`default_nettype none
package ssrep_pkg;
	// Register-bus clock figures; the block runs on that clock.
	localparam real CLK_MHZ = 250.0;
	// Hold time around an event pin transition, in register-bus clock cycles.
	localparam int unsigned MCE_HOLD_CYCLES = 10;
	// Default length of the internal self-reset sequence, in cycles.
	localparam int unsigned SELF_RST_CYCLES = 64;
	// Reset value of the event pin output level.
	localparam logic MCE_LEVEL_RST = 1'h0;

	typedef enum logic [1:0] {
		SSREP_RST_IDLE,
		SSREP_RST_HOLD_SW,
		SSREP_RST_HOLD_SELF
	} ssrep_rst_state_type;
endpackage : ssrep_pkg
`default_nettype wire

// ==== hdl/ssrep_sync.sv ====
// Two-stage synchroniser with edge pulse output.
`default_nettype none
module ssrep_sync (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rstn,
	// Asynchronous level in, synchronised level and edge pulse out.
	input  wire logic din,
	output logic      dout,
	output logic      edge_pulse
);
	typedef struct packed {
		logic meta;
		logic sync;
		logic last;
	} ssrep_sync_st_type;

	ssrep_sync_st_type s_q;
	ssrep_sync_st_type s_d;

	always_comb begin
		s_d      = s_q;
		s_d.meta = din;
		s_d.sync = s_q.meta;
		s_d.last = s_q.sync;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Only the second and third stages feed the detector; the first may be metastable.
	assign dout       = s_q.sync;
	assign edge_pulse = s_q.sync ^ s_q.last;
endmodule : ssrep_sync
`default_nettype wire

// ==== tb/ssrep_chk.sv ====
// Checker of the sideband reset, interrupt and event pin outputs.
`default_nettype none
module ssrep_chk #(
	parameter int unsigned NUM_PORTS   = 16,
	parameter int unsigned SELF_CYCLES = 64
) (
	// Clock and reset.
	input wire logic                 clk,
	input wire logic                 hard_reset_n,
	// Link reset path and interrupt output.
	input wire logic [NUM_PORTS-1:0] port_reset_req,
	input wire logic                 reset_req_clear,
	input wire logic                 self_reset_active,
	input wire logic                 link_reset_out_n_o,
	input wire logic                 link_reset_out_n_oe,
	input wire logic                 irq_out_n_o,
	// Event pin path.
	input wire logic                 mcast_dir_out,
	input wire logic                 mcast_event_pin_i,
	input wire logic                 mcast_event_pin_o,
	input wire logic [NUM_PORTS-1:0] mcast_sym_rx,
	input wire logic [NUM_PORTS-1:0] mcast_sym_en,
	input wire logic                 mcast_sym_tx_all
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!hard_reset_n);
	a_req_sets: assert property (
		!link_reset_out_n_oe && |port_reset_req |=> link_reset_out_n_oe) else $error("req lost");
	a_sw_hold: assert property (
		link_reset_out_n_oe && !self_reset_active && (!reset_req_clear || |port_reset_req)
		|=> link_reset_out_n_oe) else $error("reset dropped");
	a_sw_clear: assert property (
		link_reset_out_n_oe && !self_reset_active && reset_req_clear && ~|port_reset_req
		|=> !link_reset_out_n_oe) else $error("clear ignored");
	a_self_len: assert property (
		$rose(self_reset_active) |-> link_reset_out_n_oe ##SELF_CYCLES !link_reset_out_n_oe)
		else $error("self length");
	a_hard_rel: assert property (
		$rose(hard_reset_n) |-> !link_reset_out_n_oe) else $error("hard reset");
	a_od_low: assert property (
		link_reset_out_n_o == 1'h0 && irq_out_n_o == 1'h0) else $error("drives high");
	a_evt_in: assert property (
		!mcast_dir_out && $changed(mcast_event_pin_i) |-> ##[1:4] mcast_sym_tx_all)
		else $error("no event sent");
	a_out_toggle: assert property (
		$changed(mcast_event_pin_o) |-> $past(|(mcast_sym_rx & mcast_sym_en)))
		else $error("bad toggle");
	cover property ($rose(self_reset_active));
	cover property (mcast_sym_tx_all);
	cover property ($changed(mcast_event_pin_o));
endmodule : ssrep_chk
bind ssrep_top ssrep_chk #(.NUM_PORTS(NUM_PORTS), .SELF_CYCLES(SELF_CYCLES)) chk (.*);
`default_nettype wire

// ==== tb/ssrep_partner.sv ====
// Board side of the pins: pull-ups, pull-down and an external event pin driver.
`default_nettype none
module ssrep_partner (
	// Clock and pin drivers of the block.
	input  wire logic clk,
	input  wire logic link_reset_out_n_o,
	input  wire logic link_reset_out_n_oe,
	input  wire logic irq_out_n_o,
	input  wire logic irq_out_n_oe,
	input  wire logic mcast_event_pin_o,
	input  wire logic mcast_event_pin_oe,
	// Resolved wire levels.
	output logic      reset_wire,
	output logic      irq_wire,
	output logic      mcast_event_pin_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic ext_en = 1'h0;
	logic ext_lvl = 1'h0;
	assign reset_wire = link_reset_out_n_oe ? link_reset_out_n_o : 1'h1;
	assign irq_wire = irq_out_n_oe ? irq_out_n_o : 1'h1;
	assign mcast_event_pin_i = mcast_event_pin_oe ? mcast_event_pin_o : ext_en & ext_lvl;
	// The reference clock source is kept at or below its ceiling; this block never sees it.
	localparam real REF_CLK_MAX_MHZ = 156.25;
	// Quiet time on both sides, so one edge is never seen twice.
	task automatic toggle;
		repeat (10) @(negedge clk);
		ext_lvl = ~ext_lvl;
		repeat (10) @(negedge clk);
	endtask : toggle
endmodule : ssrep_partner
`default_nettype wire

// ==== tb/ssrep_top_bench.sv ====
// Self-checking bench of the sideband reset, interrupt and event pin logic.
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module ssrep_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0, hard_reset_n = 1'h0, self_reset_en = 1'h0, reset_req_clear = 1'h0;
	logic irq_pending = 1'h0, mcast_dir_out = 1'h0, reset_wire, irq_wire;
	logic [15:0] port_reset_req = 16'h0000, mcast_sym_rx = 16'h0000, mcast_sym_en = 16'h7FFF;
	logic self_reset_active, link_reset_out_n_o, link_reset_out_n_oe, irq_out_n_o, irq_out_n_oe;
	logic mcast_event_pin_i, mcast_event_pin_o, mcast_event_pin_oe, mcast_sym_tx_all, mcast_drop;
	int miscompares = 0, comparisons = 0, tx_seen = 0;
	// The bench clock stands for the externally supplied register-bus clock.
	initial forever #2 clk = ~clk;
	ssrep_top #(.SELF_CYCLES(4)) dut (.*);
	ssrep_partner p (.*);
	always @(posedge clk) if (mcast_sym_tx_all === 1'h1) tx_seen++;
	task automatic cyc(int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic sym(logic [15:0] v, logic e, logic d);
		mcast_sym_rx = v;
		cyc(1);
		`CHK("drop flag", d, mcast_drop)
		mcast_sym_rx = 16'h0000;
		cyc(1);
		`CHK("event pin", e, mcast_event_pin_i)
	endtask : sym
	task automatic t_reset;
		port_reset_req = 16'h8000;
		cyc(2);
		`CHK("reset held", 1'h0, reset_wire)
		reset_req_clear = 1'h1;
		port_reset_req = 16'h0001;
		cyc(2);
		reset_req_clear = 1'h0;
		`CHK("clear with req", 1'h0, reset_wire)
		port_reset_req = 16'h0000;
		reset_req_clear = 1'h1;
		cyc(2);
		`CHK("cleared", 1'h1, reset_wire)
		reset_req_clear = 1'h0;
		port_reset_req = 16'h0001;
		cyc(1);
		port_reset_req = 16'h0000;
		cyc(2);
		hard_reset_n = 1'h0;
		cyc(1);
		`CHK("hard reset", 1'h1, reset_wire)
		hard_reset_n = 1'h1;
		cyc(3);
		`CHK("after hard", 1'h1, reset_wire)
	endtask : t_reset
	task automatic t_self;
		self_reset_en = 1'h1;
		port_reset_req = 16'h0004;
		cyc(1);
		port_reset_req = 16'h0000;
		cyc(3);
		`CHK("self held", 1'h0, reset_wire)
		`CHK("self active", 1'h1, self_reset_active)
		cyc(1);
		`CHK("self done", 1'h1, reset_wire)
		`CHK("self ended", 1'h0, self_reset_active)
	endtask : t_self
	task automatic t_evt;
		irq_pending = 1'h1;
		p.ext_en = 1'h1;
		p.toggle();
		p.toggle();
		`CHK("irq", 1'h0, irq_wire)
		`CHK("events", 2, tx_seen)
		p.ext_en = 1'h0;
		mcast_dir_out = 1'h1;
		cyc(2);
		sym(16'h0001, 1'h1, 1'h0);
		sym(16'h0002, 1'h1, 1'h1);
		cyc(10);
		sym(16'h8000, 1'h1, 1'h0);
		sym(16'h0001, 1'h0, 1'h0);
		irq_pending = 1'h0;
		cyc(2);
		`CHK("irq released", 1'h1, irq_wire)
	endtask : t_evt
	task automatic tally_and_finish;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		#5us;
		miscompares++;
		tally_and_finish();
	end
	initial begin
		cyc(8);
		hard_reset_n = 1'h1;
		cyc(1);
		t_reset();
		t_self();
		t_evt();
		tally_and_finish();
	end
endmodule : ssrep_top_bench
`default_nettype wire
